// ---- pdfsb_map.svh ----
// Register indices, field positions, reset values and widths of the fault status bank
`ifndef PDFSB_MAP_SVH
`define PDFSB_MAP_SVH

`define PDFSB_IDX_W            11
`define PDFSB_IDX_HOT          11'h540
`define PDFSB_IDX_COLD         11'h541
`define PDFSB_IDX_INCMP        11'h543
`define PDFSB_IDX_CELLCMP_HI   11'h545
`define PDFSB_IDX_CELLCMP_LO   11'h546
`define PDFSB_IDX_CELLOW_HI    11'h548
`define PDFSB_IDX_CELLOW_LO    11'h549
`define PDFSB_IDX_BALOW_HI     11'h54B
`define PDFSB_IDX_BALOW_LO     11'h54C
`define PDFSB_IDX_BALSW_HI     11'h54E
`define PDFSB_IDX_BALSW_LO     11'h54F
`define PDFSB_IDX_MISC         11'h550
`define PDFSB_IDX_IN_THR       11'h560
`define PDFSB_IDX_CELL_THR     11'h561
`define PDFSB_IDX_OPENWIRE_THRESHOLD       11'h562
`define PDFSB_IDX_FAULT_CLR    11'h564
`define PDFSB_IDX_IRQ_STATUS   11'h568
`define PDFSB_IDX_IRQ_MASK     11'h569

`define PDFSB_NUM_FLAGS        12
`define PDFSB_FLAG_W           8
`define PDFSB_FLAG_RESET       8'h00
`define PDFSB_MISC_ABORT_BIT   1
`define PDFSB_MISC_FILTER_BIT  0

`define PDFSB_RDG_W            16
`define PDFSB_NUM_INPUTS       8
`define PDFSB_NUM_CELLS        16
`define PDFSB_IN_THR_W         3
`define PDFSB_CELL_THR_W       5
`define PDFSB_OPENWIRE_THRESHOLD_W         4
`define PDFSB_IN_THR_RESET     3'h0
`define PDFSB_CELL_THR_RESET   5'h00
`define PDFSB_OPENWIRE_THRESHOLD_RESET     4'h0
`define PDFSB_IRQ_RESET        12'h000

`endif

// ---- pdfsb_pkg.sv ----
// Types shared by the fault status bank
package pdfsb_pkg;
  `include "pdfsb_map.svh"

  typedef enum logic {
    PDFSB_BUS_IDLE   = 1'b0,
    PDFSB_BUS_ANSWER = 1'b1
  } pdfsb_bus_state_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [12:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pdfsb_avl_req_type;

  typedef struct packed {
    logic [`PDFSB_NUM_INPUTS-1:0]                   input_hot_flag;
    logic [`PDFSB_NUM_INPUTS-1:0]                   input_cold_flag;
    logic                                           cmp_done;
    logic                                           cmp_abort;
    logic [`PDFSB_NUM_INPUTS-1:0][`PDFSB_RDG_W-1:0] main_input_reading;
    logic [`PDFSB_NUM_INPUTS-1:0][`PDFSB_RDG_W-1:0] aux_input_reading;
    logic [`PDFSB_NUM_CELLS-1:0][`PDFSB_RDG_W-1:0]  main_cell_reading;
    logic [`PDFSB_NUM_CELLS-1:0][`PDFSB_RDG_W-1:0]  aux_cell_reading;
    logic                                           openwire_done;
    logic                                           balance_done;
    logic [`PDFSB_NUM_CELLS-1:0]                    balance_openwire_fail;
    logic [`PDFSB_NUM_CELLS-1:0]                    balance_switch_fail;
    logic                                           filter_done;
    logic                                           filter_diag_fail;
  } pdfsb_diag_type;

  typedef struct packed {
    pdfsb_bus_state_type             bus_state;
    logic [31:0]                     rdata;
    logic [`PDFSB_IN_THR_W-1:0]      in_thr;
    logic [`PDFSB_CELL_THR_W-1:0]    cell_thr;
    logic [`PDFSB_OPENWIRE_THRESHOLD_W-1:0]      openwire_threshold;
    logic [`PDFSB_NUM_FLAGS-1:0]     fault_clr;
    logic [`PDFSB_NUM_FLAGS-1:0]     irq_status;
    logic [`PDFSB_NUM_FLAGS-1:0]     irq_mask;
    logic                            irq;
  } pdfsb_top_state_type;

  typedef struct packed {
    logic [`PDFSB_FLAG_W-1:0] q;
  } pdfsb_flag_state_type;
endpackage : pdfsb_pkg

// ---- pdfsb_compare.sv ----
// Per-channel main versus auxiliary reading comparison against a scaled threshold
`timescale 1ns/100ps
module pdfsb_compare #(
  parameter int N     = 8,
  parameter int W     = 16,
  parameter int TW    = 3,
  parameter int SHIFT = 0
) (
  input  wire logic [N-1:0][W-1:0] main_rdg,
  input  wire logic [N-1:0][W-1:0] aux_rdg,
  input  wire logic [TW-1:0]       thr,
  output logic      [N-1:0]        fail
);
  logic [W-1:0] thr_scaled;

  // Threshold step size is not fixed, so one code step is 2**SHIFT reading counts
  assign thr_scaled = W'({{(W-TW){1'b0}}, thr} << SHIFT);

  for (genvar i = 0; i < N; i++) begin : g_ch
    logic [W-1:0] diff;
    assign diff    = (main_rdg[i] > aux_rdg[i]) ? W'(main_rdg[i] - aux_rdg[i])
                                                : W'(aux_rdg[i] - main_rdg[i]);
    assign fail[i] = diff > thr_scaled;
  end
endmodule : pdfsb_compare

// ---- pdfsb_flag_reg.sv ----
// One read-only fault status byte: sticky sets, per-run loads, fault clear
`timescale 1ns/100ps
module pdfsb_flag_reg #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_bits,
  input  wire logic [W-1:0] load_mask,
  input  wire logic [W-1:0] load_val,
  input  wire logic         clear,
  output logic      [W-1:0] q,
  output logic              rose
);
  pdfsb_pkg::pdfsb_flag_state_type state_r;
  pdfsb_pkg::pdfsb_flag_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    // Set beats clear so an event in the clearing cycle survives
    state_nxt.q = (state_r.q & ~({W{clear}} | load_mask)) | (load_val & load_mask) | set_bits;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r.q <= `PDFSB_FLAG_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q    = state_r.q;
  assign rose = |(state_nxt.q & ~state_r.q);
endmodule : pdfsb_flag_reg

// ---- pdfsb_bank.sv ----
// Fault status bank top: Avalon-MM slave, diagnostic flag capture, interrupt
`timescale 1ns/100ps
module pdfsb_bank #(
  parameter int THR_SHIFT = 0
) (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire pdfsb_pkg::pdfsb_avl_req_type avs_req,
  output logic                          avs_waitrequest,
  output logic [31:0]                   avs_readdata,
  input  wire pdfsb_pkg::pdfsb_diag_type diag,
  output logic                          irq
);
  localparam int NF = `PDFSB_NUM_FLAGS;
  localparam int FW = `PDFSB_FLAG_W;
  localparam int NI = `PDFSB_NUM_INPUTS;
  localparam int NC = `PDFSB_NUM_CELLS;
  localparam int RW = `PDFSB_RDG_W;

  localparam logic [4:0] SEL_IN_THR   = 5'h0C;
  localparam logic [4:0] SEL_CELL_THR = 5'h0D;
  localparam logic [4:0] SEL_OPENWIRE_THRESHOLD   = 5'h0E;
  localparam logic [4:0] SEL_FCLR     = 5'h0F;
  localparam logic [4:0] SEL_IST      = 5'h10;
  localparam logic [4:0] SEL_IMASK    = 5'h11;
  localparam logic [4:0] SEL_NONE     = 5'h1F;

  logic rst_meta_r;
  logic rst_sync_r;

  pdfsb_pkg::pdfsb_top_state_type state_r;
  pdfsb_pkg::pdfsb_top_state_type state_nxt;

  logic [NF-1:0][FW-1:0] flag_q;
  logic [NF-1:0][FW-1:0] flag_set;
  logic [NF-1:0][FW-1:0] flag_lmask;
  logic [NF-1:0][FW-1:0] flag_lval;
  logic [NF-1:0]         flag_rose;

  logic [NI-1:0] input_compare_fail;
  logic [NC-1:0] cell_compare_fail;
  logic [NC-1:0] cell_openwire_fail;
  logic          cmp_ok;

  // Register index to select code; flag slots 0 to 11 follow address order
  function automatic logic [4:0] pdfsb_decode(input logic [`PDFSB_IDX_W-1:0] idx);
    logic [4:0] sel;
    sel = SEL_NONE;
    case (idx)
      `PDFSB_IDX_HOT:        sel = 5'h00;
      `PDFSB_IDX_COLD:       sel = 5'h01;
      `PDFSB_IDX_INCMP:      sel = 5'h02;
      `PDFSB_IDX_CELLCMP_HI: sel = 5'h03;
      `PDFSB_IDX_CELLCMP_LO: sel = 5'h04;
      `PDFSB_IDX_CELLOW_HI:  sel = 5'h05;
      `PDFSB_IDX_CELLOW_LO:  sel = 5'h06;
      `PDFSB_IDX_BALOW_HI:   sel = 5'h07;
      `PDFSB_IDX_BALOW_LO:   sel = 5'h08;
      `PDFSB_IDX_BALSW_HI:   sel = 5'h09;
      `PDFSB_IDX_BALSW_LO:   sel = 5'h0A;
      `PDFSB_IDX_MISC:       sel = 5'h0B;
      `PDFSB_IDX_IN_THR:     sel = SEL_IN_THR;
      `PDFSB_IDX_CELL_THR:   sel = SEL_CELL_THR;
      `PDFSB_IDX_OPENWIRE_THRESHOLD:     sel = SEL_OPENWIRE_THRESHOLD;
      `PDFSB_IDX_FAULT_CLR:  sel = SEL_FCLR;
      `PDFSB_IDX_IRQ_STATUS: sel = SEL_IST;
      `PDFSB_IDX_IRQ_MASK:   sel = SEL_IMASK;
      default:               sel = SEL_NONE;
    endcase
    return sel;
  endfunction : pdfsb_decode

  // Reset released through two flops; only the second is used
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  pdfsb_compare #(
    .N     (NI),
    .W     (RW),
    .TW    (`PDFSB_IN_THR_W),
    .SHIFT (THR_SHIFT)
  ) u_input_cmp (
    .main_rdg (diag.main_input_reading),
    .aux_rdg  (diag.aux_input_reading),
    .thr      (state_r.in_thr),
    .fail     (input_compare_fail)
  );

  pdfsb_compare #(
    .N     (NC),
    .W     (RW),
    .TW    (`PDFSB_CELL_THR_W),
    .SHIFT (THR_SHIFT)
  ) u_cell_cmp (
    .main_rdg (diag.main_cell_reading),
    .aux_rdg  (diag.aux_cell_reading),
    .thr      (state_r.cell_thr),
    .fail     (cell_compare_fail)
  );

  for (genvar c = 0; c < NC; c++) begin : g_ow
    logic [RW-1:0] ow_scaled;
    assign ow_scaled = RW'({{(RW-`PDFSB_OPENWIRE_THRESHOLD_W){1'b0}}, state_r.openwire_threshold} << THR_SHIFT);
    assign cell_openwire_fail[c] = diag.main_cell_reading[c] < ow_scaled;
  end

  // Per-run comparison results replace old ones only on a clean finish
  assign cmp_ok = diag.cmp_done & ~diag.cmp_abort;

  always_comb begin
    flag_set   = '0;
    flag_lmask = '0;
    flag_lval  = '0;
    // Input n lands in bit n of each input register
    flag_set[0] = diag.input_hot_flag;
    flag_set[1] = diag.input_cold_flag;
    flag_lmask[2] = {FW{cmp_ok}};
    flag_lval[2]  = input_compare_fail;
    flag_lmask[3] = {FW{cmp_ok}};
    flag_lval[3]  = cell_compare_fail[NC-1:FW];
    flag_lmask[4] = {FW{cmp_ok}};
    flag_lval[4]  = cell_compare_fail[FW-1:0];
    if (diag.openwire_done) begin
      flag_set[5] = cell_openwire_fail[NC-1:FW];
      flag_set[6] = cell_openwire_fail[FW-1:0];
    end
    if (diag.balance_done) begin
      flag_set[7]  = diag.balance_openwire_fail[NC-1:FW];
      flag_set[8]  = diag.balance_openwire_fail[FW-1:0];
      flag_set[9]  = diag.balance_switch_fail[NC-1:FW];
      flag_set[10] = diag.balance_switch_fail[FW-1:0];
    end
    // Abort bit tracks only the latest run, so it is loaded, not made sticky
    flag_lmask[11][`PDFSB_MISC_ABORT_BIT] = diag.cmp_done;
    flag_lval[11][`PDFSB_MISC_ABORT_BIT]  = diag.cmp_abort;
    flag_set[11][`PDFSB_MISC_FILTER_BIT]  = diag.filter_done & diag.filter_diag_fail;
  end

  for (genvar f = 0; f < NF; f++) begin : g_flag
    pdfsb_flag_reg #(
      .W (FW)
    ) u_flag (
      .clk_sys   (clk_sys),
      .rst_n     (rst_sync_r),
      .set_bits  (flag_set[f]),
      .load_mask (flag_lmask[f]),
      .load_val  (flag_lval[f]),
      .clear     (state_r.fault_clr[f]),
      .q         (flag_q[f]),
      .rose      (flag_rose[f])
    );
  end

  always_comb begin
    logic [4:0]    sel;
    logic          wr_commit;
    logic          lane0;
    logic          lane1;
    logic [NF-1:0] w1c;
    sel       = pdfsb_decode(avs_req.address[12:2]);
    wr_commit = 1'b0;
    lane0     = avs_req.byteenable[0];
    lane1     = avs_req.byteenable[1];
    w1c       = '0;
    state_nxt = state_r;
    state_nxt.fault_clr = '0;

    case (state_r.bus_state)
      pdfsb_pkg::PDFSB_BUS_IDLE: begin
        // Read data is prepared one cycle ahead and held through the answer
        if (avs_req.read || avs_req.write) begin
          state_nxt.bus_state = pdfsb_pkg::PDFSB_BUS_ANSWER;
          state_nxt.rdata     = '0;
          if (avs_req.read) begin
            if (sel < 5'(NF)) begin
              state_nxt.rdata[FW-1:0] = flag_q[sel[3:0]];
            end else begin
              case (sel)
                SEL_IN_THR:   state_nxt.rdata[`PDFSB_IN_THR_W-1:0]   = state_r.in_thr;
                SEL_CELL_THR: state_nxt.rdata[`PDFSB_CELL_THR_W-1:0] = state_r.cell_thr;
                SEL_OPENWIRE_THRESHOLD:   state_nxt.rdata[`PDFSB_OPENWIRE_THRESHOLD_W-1:0]   = state_r.openwire_threshold;
                SEL_IST:      state_nxt.rdata[NF-1:0]                = state_r.irq_status;
                SEL_IMASK:    state_nxt.rdata[NF-1:0]                = state_r.irq_mask;
                default:      state_nxt.rdata = '0;
              endcase
            end
          end
        end
      end
      pdfsb_pkg::PDFSB_BUS_ANSWER: begin
        state_nxt.bus_state = pdfsb_pkg::PDFSB_BUS_IDLE;
        wr_commit           = avs_req.write;
      end
      default: begin
        state_nxt.bus_state = pdfsb_pkg::PDFSB_BUS_IDLE;
      end
    endcase

    // Status bytes ignore writes; only own control registers take data
    if (wr_commit) begin
      case (sel)
        SEL_IN_THR: begin
          if (lane0) state_nxt.in_thr = avs_req.writedata[`PDFSB_IN_THR_W-1:0];
        end
        SEL_CELL_THR: begin
          if (lane0) state_nxt.cell_thr = avs_req.writedata[`PDFSB_CELL_THR_W-1:0];
        end
        SEL_OPENWIRE_THRESHOLD: begin
          if (lane0) state_nxt.openwire_threshold = avs_req.writedata[`PDFSB_OPENWIRE_THRESHOLD_W-1:0];
        end
        SEL_FCLR: begin
          if (lane0) state_nxt.fault_clr[7:0] = avs_req.writedata[7:0];
          if (lane1) state_nxt.fault_clr[NF-1:8] = avs_req.writedata[NF-1:8];
        end
        SEL_IST: begin
          if (lane0) w1c[7:0] = avs_req.writedata[7:0];
          if (lane1) w1c[NF-1:8] = avs_req.writedata[NF-1:8];
        end
        SEL_IMASK: begin
          if (lane0) state_nxt.irq_mask[7:0] = avs_req.writedata[7:0];
          if (lane1) state_nxt.irq_mask[NF-1:8] = avs_req.writedata[NF-1:8];
        end
        default: begin
        end
      endcase
    end

    // A new fault in the clearing cycle keeps its status bit
    state_nxt.irq_status = (state_r.irq_status & ~w1c) | flag_rose;
    state_nxt.irq        = |(state_nxt.irq_status & state_nxt.irq_mask);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r.bus_state  <= pdfsb_pkg::PDFSB_BUS_IDLE;
      state_r.rdata      <= 32'h00000000;
      state_r.in_thr     <= `PDFSB_IN_THR_RESET;
      state_r.cell_thr   <= `PDFSB_CELL_THR_RESET;
      state_r.openwire_threshold     <= `PDFSB_OPENWIRE_THRESHOLD_RESET;
      state_r.fault_clr  <= `PDFSB_IRQ_RESET;
      state_r.irq_status <= `PDFSB_IRQ_RESET;
      state_r.irq_mask   <= `PDFSB_IRQ_RESET;
      state_r.irq        <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Waitrequest is high whenever no answer is being given
  assign avs_waitrequest = (state_r.bus_state == pdfsb_pkg::PDFSB_BUS_IDLE);
  assign avs_readdata    = state_r.rdata;
  assign irq             = state_r.irq;
endmodule : pdfsb_bank

// ---- pdfsb_bank_props.sv ----
// Port-level assertions for the fault status bank
`timescale 1ns/100ps
`include "pdfsb_map.svh"
module pdfsb_bank_props #(
  parameter int THR_SHIFT = 0
) (
  input wire logic                         clk_sys,
  input wire logic                         resetn,
  input wire pdfsb_pkg::pdfsb_avl_req_type avs_req,
  input wire logic                         avs_waitrequest,
  input wire logic [31:0]                  avs_readdata,
  input wire pdfsb_pkg::pdfsb_diag_type    diag,
  input wire logic                         irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic        req_on = avs_req.read | avs_req.write;
  wire logic [10:0] idx    = avs_req.address[12:2];
  wire logic        ans    = !avs_waitrequest;
  // Any diagnostic input that can set a status bit
  wire logic        ev     = (|diag.input_hot_flag) | (|diag.input_cold_flag) | diag.cmp_done
                             | diag.openwire_done | diag.balance_done | diag.filter_done;
  sequence s_take;
    avs_waitrequest && req_on;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_ONE_WAIT:
    assert property (s_take |=> s_answer) else $error("answer not one cycle after take");
  AST_NO_SPONT:
    assert property (avs_waitrequest && !req_on |=> avs_waitrequest) else $error("answer without request");
  AST_RDATA_STANDS:
    assert property ($changed(avs_readdata) |-> ans) else $error("read data moved outside answer");
  AST_MISC_RESERVED:
    assert property (ans && idx == `PDFSB_IDX_MISC |-> avs_readdata[31:2] == 30'h0)
      else $error("reserved misc bits not zero");
  AST_FLAG_UPPER:
    assert property (ans && idx >= `PDFSB_IDX_HOT && idx <= `PDFSB_IDX_MISC
      |-> avs_readdata[31:8] == 24'h0) else $error("status read upper bits not zero");
  AST_HOT_SEEN:
    assert property (ans && avs_req.read && idx == `PDFSB_IDX_HOT |-> (avs_readdata[7:0]
      & $past(diag.input_hot_flag, 2)) == $past(diag.input_hot_flag, 2)) else $error("hot bit lost");
  AST_COLD_SEEN:
    assert property (ans && avs_req.read && idx == `PDFSB_IDX_COLD |-> (avs_readdata[7:0]
      & $past(diag.input_cold_flag, 2)) == $past(diag.input_cold_flag, 2)) else $error("cold bit lost");
  AST_IRQ_FALL:
    assert property ($fell(irq) |-> $past(avs_req.write, 2)) else $error("irq fell without write");
  AST_IRQ_RISE:
    // Status and irq flops load at the edge that samples the cause
    assert property ($rose(irq) |-> $past(ev | avs_req.write)) else $error("irq rose without cause");
endmodule : pdfsb_bank_props

// ---- tb_top.sv ----
// Self-checking bench for the fault status bank
`timescale 1ns/100ps
`include "pdfsb_map.svh"
module tb_top;
  logic                         clk_sys;
  logic                         resetn;
  pdfsb_pkg::pdfsb_avl_req_type req;
  pdfsb_pkg::pdfsb_diag_type    diag;
  logic                         avs_waitrequest;
  logic [31:0]                  avs_readdata;
  logic                         irq;
  int                           n_errors;
  int                           n_tests;
  int                           seed;
  int                           i;
  logic [42:0]                  expq[$];
  logic [15:0]                  pa;
  logic [15:0]                  pb;
  logic [10:0]                  ix[12];

  pdfsb_bank #(.THR_SHIFT(0)) DUT (.clk_sys(clk_sys), .resetn(resetn), .avs_req(req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .diag(diag), .irq(irq));

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  task automatic cmp(input logic [10:0] a, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD reg %h exp %h got %h", a, e, g);
    end
  endtask : cmp
  task automatic chk_irq(input logic e);
    n_tests++;
    if (irq !== e) begin
      n_errors++;
      $display("BAD irq exp %b got %b", e, irq);
    end
  endtask : chk_irq
  // Request stays up after the answer so back-to-back calls need no idle cycle
  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
    req.read <= !wr;
    req.write <= wr;
    req.address <= {a, 2'b00};
    req.writedata <= d;
    req.byteenable <= 4'h3;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
  endtask : bus
  task automatic rd(input logic [10:0] a, input logic [31:0] e);
    expq.push_back({a, e});
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic idle();
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_sys);
  endtask : idle
  task automatic pulse(input logic [3:0] k);
    {diag.cmp_done, diag.openwire_done, diag.balance_done, diag.filter_done} <= k;
    @(posedge clk_sys);
    {diag.cmp_done, diag.openwire_done, diag.balance_done, diag.filter_done} <= 4'h0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_sys) begin : mon
    logic [42:0] e;
    if (avs_waitrequest === 1'b0 && req.read === 1'b1) begin
      e = expq.pop_front();
      cmp(e[42:32], e[31:0], avs_readdata);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("BAD watchdog exp end got hang");
    summarize();
  end

  initial begin
    seed = 62273;
    n_errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    req = '0;
    diag = '0;
    ix = '{`PDFSB_IDX_HOT, `PDFSB_IDX_COLD, `PDFSB_IDX_INCMP, `PDFSB_IDX_CELLCMP_HI,
      `PDFSB_IDX_CELLCMP_LO, `PDFSB_IDX_CELLOW_HI, `PDFSB_IDX_CELLOW_LO, `PDFSB_IDX_BALOW_HI,
      `PDFSB_IDX_BALOW_LO, `PDFSB_IDX_BALSW_HI, `PDFSB_IDX_BALSW_LO, `PDFSB_IDX_MISC};
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (i = 0; i < 12; i++) begin
      rd(ix[i], 32'h0);
      wr(ix[i], 32'hFF);
      rd(ix[i], 32'h0);
    end
    rd(11'h7FF, 32'h0);
    idle();
    $display("test reset_values done");
    pa = 16'($random(seed));
    pa[0] = 1'b1;
    pa[8] = 1'b1;
    diag.input_hot_flag <= pa[7:0];
    diag.input_cold_flag <= pa[15:8];
    @(posedge clk_sys);
    diag.input_hot_flag <= 8'h00;
    diag.input_cold_flag <= 8'h00;
    @(posedge clk_sys);
    rd(ix[0], {24'h0, pa[7:0]});
    rd(ix[1], {24'h0, pa[15:8]});
    rd(`PDFSB_IDX_IRQ_STATUS, 32'h3);
    wr(`PDFSB_IDX_IRQ_MASK, 32'h1);
    idle();
    repeat (2) @(posedge clk_sys);
    chk_irq(1'b1);
    wr(`PDFSB_IDX_IRQ_STATUS, 32'h1);
    idle();
    repeat (2) @(posedge clk_sys);
    chk_irq(1'b0);
    rd(`PDFSB_IDX_IRQ_STATUS, 32'h2);
    rd(ix[0], {24'h0, pa[7:0]});
    wr(`PDFSB_IDX_FAULT_CLR, 32'h1);
    idle();
    rd(ix[0], 32'h0);
    rd(ix[1], {24'h0, pa[15:8]});
    wr(`PDFSB_IDX_IN_THR, 32'h2);
    wr(`PDFSB_IDX_CELL_THR, 32'h3);
    wr(`PDFSB_IDX_OPENWIRE_THRESHOLD, 32'h5);
    idle();
    // Unmasked event alone must raise the interrupt
    diag.input_hot_flag <= 8'h01;
    @(posedge clk_sys);
    diag.input_hot_flag <= 8'h00;
    @(posedge clk_sys);
    chk_irq(1'b1);
    $display("test temp_irq done");
    // Differences of exactly the threshold must pass, one more must fail
    pa = 16'($random(seed));
    pb = 16'($random(seed));
    for (i = 0; i < 16; i++) begin
      diag.main_cell_reading[i] <= pb[i] ? 16'h2004 : 16'h2003;
      diag.aux_cell_reading[i] <= 16'h2000;
      if (i < 8) begin
        diag.main_input_reading[i] <= 16'h1000;
        diag.aux_input_reading[i] <= pa[i] ? 16'h1003 : 16'h1002;
      end
    end
    pulse(4'h8);
    rd(`PDFSB_IDX_INCMP, {24'h0, pa[7:0]});
    rd(`PDFSB_IDX_CELLCMP_HI, {24'h0, pb[15:8]});
    rd(`PDFSB_IDX_CELLCMP_LO, {24'h0, pb[7:0]});
    rd(`PDFSB_IDX_MISC, 32'h0);
    idle();
    for (i = 0; i < 16; i++) begin
      diag.main_cell_reading[i] <= 16'h2000;
      if (i < 8) begin
        diag.aux_input_reading[i] <= 16'h1000;
      end
    end
    diag.cmp_abort <= 1'b1;
    pulse(4'h8);
    rd(`PDFSB_IDX_INCMP, {24'h0, pa[7:0]});
    rd(`PDFSB_IDX_MISC, 32'h2);
    idle();
    diag.cmp_abort <= 1'b0;
    pulse(4'h8);
    rd(`PDFSB_IDX_INCMP, 32'h0);
    rd(`PDFSB_IDX_CELLCMP_HI, 32'h0);
    rd(`PDFSB_IDX_MISC, 32'h0);
    idle();
    $display("test compare done");
    pb = 16'($random(seed));
    for (i = 0; i < 16; i++) begin
      diag.main_cell_reading[i] <= pb[i] ? 16'h0004 : 16'h0005;
    end
    pulse(4'h4);
    rd(`PDFSB_IDX_CELLOW_HI, {24'h0, pb[15:8]});
    rd(`PDFSB_IDX_CELLOW_LO, {24'h0, pb[7:0]});
    idle();
    pa = 16'($random(seed));
    pb = 16'($random(seed));
    diag.balance_openwire_fail <= pa;
    diag.balance_switch_fail <= pb;
    pulse(4'h2);
    diag.balance_openwire_fail <= 16'h0;
    diag.balance_switch_fail <= 16'h0;
    pulse(4'h2);
    rd(`PDFSB_IDX_BALOW_HI, {24'h0, pa[15:8]});
    rd(`PDFSB_IDX_BALOW_LO, {24'h0, pa[7:0]});
    rd(`PDFSB_IDX_BALSW_HI, {24'h0, pb[15:8]});
    rd(`PDFSB_IDX_BALSW_LO, {24'h0, pb[7:0]});
    idle();
    diag.filter_diag_fail <= 1'b1;
    pulse(4'h1);
    diag.filter_diag_fail <= 1'b0;
    pulse(4'h1);
    rd(`PDFSB_IDX_MISC, 32'h1);
    wr(`PDFSB_IDX_FAULT_CLR, 32'hFFF);
    idle();
    for (i = 0; i < 12; i++) begin
      rd(ix[i], 32'h0);
    end
    idle();
    $display("test wire_balance_filter done");
    summarize();
  end
endmodule : tb_top

bind pdfsb_bank pdfsb_bank_props #(.THR_SHIFT(THR_SHIFT)) u_props (.clk_sys(clk_sys),
  .resetn(resetn), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .diag(diag), .irq(irq));
